// File: core/spi_eeprom_consts.svh
// constants of the spi eeprom array access and protection core
`ifndef SPI_EEPROM_CONSTS_SVH
`define SPI_EEPROM_CONSTS_SVH
`define OP_STATUS_SET 8'h01
`define OP_WRITE      8'h02
`define OP_READ       8'h03
`define OP_WRDI       8'h04
`define OP_RDSR       8'h05
`define OP_ARM        8'h06
`define LOCK_B        7
`define HI_B          3
`define LO_B          2
`define BYTE_W        8
`define ADDR_W        11
`define ADDR_TOP_W    3
`define MEM_DEPTH     2048
`define PAGE_W        5
`define PAGE_BYTES    32
`define PAGE_BASE_W   6
`define ADDR_MAX      11'h7ff
`define OFFSET_MAX    5'h1f
`define GUARD_QUARTER 11'h600
`define GUARD_HALF    11'h400
`define LAST_BIT      3'h7
`define FIRST_BIT     3'h0
`define ZERO_BYTE     8'h00
`define STATUS_PAD    3'h0
`define FIFO_DEPTH    8
`define CLK_FREQ_MHZ  25
`define PROG_TIME_US  5000
`define PROG_CYCLES   (`PROG_TIME_US * `CLK_FREQ_MHZ)
`define CNT_W         17
`define CNT_ZERO      17'h00000
`endif

// File: core/spi_eeprom_pkg.sv
// types of the spi eeprom core
package spi_eeprom_pkg;
  typedef enum logic [2:0] {
    ST_OPCODE = 3'b000,
    ST_ADDR   = 3'b001,
    ST_RDATA  = 3'b010,
    ST_WDATA  = 3'b011,
    ST_SDATA  = 3'b100,
    ST_STATUS = 3'b101,
    ST_IGNORE = 3'b110
  } phase_type;
  typedef struct packed {
    logic sck;
    logic csB;
    logic mosi;
    logic wpB;
  } pin_type;
  typedef struct packed {
    logic lock;
    logic hi;
    logic lo;
  } guard_type;
endpackage : spi_eeprom_pkg

// File: core/byte_fifo.sv
// read prefetch fifo with flush
`timescale 1ns/100ps
module byte_fifo
#(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
)
(
  input  wire logic             clk,
  input  wire logic             rst_b,
  input  wire logic             flush,
  input  wire logic [WIDTH-1:0] inData,
  input  wire logic             inValid,
  output logic                  inReady,
  output logic      [WIDTH-1:0] outData,
  output logic                  outValid,
  input  wire logic             outReady
);
  localparam int PTR_W = $clog2(DEPTH);
  logic [WIDTH-1:0] store [0:DEPTH-1];
  logic [PTR_W:0]   wrPtr;
  logic [PTR_W:0]   rdPtr;
  logic [PTR_W:0]   next_wrPtr;
  logic [PTR_W:0]   next_rdPtr;
  logic             push;
  logic             pop;
  logic             full;

  assign full     = (wrPtr[PTR_W] != rdPtr[PTR_W]) && (wrPtr[PTR_W-1:0] == rdPtr[PTR_W-1:0]);
  assign inReady  = !flush && !full;
  assign outValid = !flush && (wrPtr != rdPtr);
  assign outData  = store[rdPtr[PTR_W-1:0]];
  assign push     = inValid && inReady;
  assign pop      = outValid && outReady;

  always_comb
  begin
    next_wrPtr = wrPtr;
    next_rdPtr = rdPtr;
    if (flush)
    begin
      next_wrPtr = '0;
      next_rdPtr = '0;
    end
    else
    begin
      if (push)
        next_wrPtr = wrPtr + 1'b1;
      if (pop)
        next_rdPtr = rdPtr + 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      wrPtr <= '0;
      rdPtr <= '0;
    end
    else
    begin
      wrPtr <= next_wrPtr;
      rdPtr <= next_rdPtr;
    end
  end

  always_ff @(posedge clk)
  begin
    if (push)
      store[wrPtr[PTR_W-1:0]] <= inData;
  end
endmodule : byte_fifo

// File: core/spi_eeprom_core.sv
// spi eeprom array access and write protection core
`timescale 1ns/100ps
`include "spi_eeprom_consts.svh"
module spi_eeprom_core
#(
  parameter int PROG_CYCLES = `PROG_CYCLES
)
(
  input  wire logic clk,
  input  wire logic rst_b,
  input  wire logic sck,
  input  wire logic csB,
  input  wire logic mosi,
  input  wire logic writeProtectB,
  output logic      miso,
  output logic      misoEnB,
  output logic      busyFlag,
  output logic      armLatch,
  output logic      guardLockBit,
  output logic      guardLevelHi,
  output logic      guardLevelLo,
  output logic      hardLockMode,
  output logic      softGuardMode
);
  logic [`BYTE_W-1:0]      mem [0:`MEM_DEPTH-1];
  logic [`BYTE_W-1:0]      pageBuf [0:`PAGE_BYTES-1];
  spi_eeprom_pkg::pin_type   pinIn, sync1, sync2, sync3, pins, pinsDly;
  spi_eeprom_pkg::pin_type   next_pins;
  spi_eeprom_pkg::phase_type phase, next_phase;
  spi_eeprom_pkg::guard_type statusNew, next_statusNew;
  logic [2:0]              bitCnt, next_bitCnt;
  logic [`BYTE_W-1:0]      shiftIn, next_shiftIn, shiftOut, next_shiftOut;
  logic [`BYTE_W-1:0]      addrHi, next_addrHi, inByte, loadByte, statusByte;
  logic                    addrSecond, next_addrSecond, isWrite, next_isWrite;
  logic [`ADDR_W-1:0]      readAddr, next_readAddr, fullAddr;
  logic [`PAGE_BASE_W-1:0] pageBase, next_pageBase;
  logic [`PAGE_W-1:0]      pageOffset, next_pageOffset;
  logic [`PAGE_BYTES-1:0]  pageValid, next_pageValid;
  logic                    gotData, next_gotData, pendStatus, next_pendStatus;
  logic                    progArray, next_progArray;
  logic [`CNT_W-1:0]       progCnt, next_progCnt;
  logic                    next_miso, next_misoEnB, next_busy, next_arm;
  logic                    next_lock, next_hi, next_lo, next_hard, next_soft;
  logic                    selected, sckRise, sckFall, csRise, lastBit, hardLock;
  logic                    decodeEvt, byteStore, commit, outPhase;
  logic                    fifoReady, fifoValid, fifoPop, pushValid;
  logic [`BYTE_W-1:0]      fifoOut;

  function automatic logic inGuard(input logic [`ADDR_W-1:0] a, input logic hi, input logic lo);
    case ({hi, lo})
      2'b01:   inGuard = (a >= `GUARD_QUARTER);
      2'b10:   inGuard = (a >= `GUARD_HALF);
      2'b11:   inGuard = 1'b1;
      default: inGuard = 1'b0;
    endcase
  endfunction : inGuard

  assign pinIn = '{sck: sck, csB: csB, mosi: mosi, wpB: writeProtectB};

  byte_fifo
  #(
    .WIDTH (`BYTE_W),
    .DEPTH (`FIFO_DEPTH)
  )
  prefetch
  (
    .clk      (clk),
    .rst_b    (rst_b),
    .flush    (pins.csB),
    .inData   (mem[readAddr]),
    .inValid  (pushValid),
    .inReady  (fifoReady),
    .outData  (fifoOut),
    .outValid (fifoValid),
    .outReady (fifoPop)
  );

  always_comb
  begin
    next_pins = pins;
    if (sync2.sck == sync3.sck)
      next_pins.sck = sync2.sck;
    if (sync2.csB == sync3.csB)
      next_pins.csB = sync2.csB;
    if (sync2.mosi == sync3.mosi)
      next_pins.mosi = sync2.mosi;
    if (sync2.wpB == sync3.wpB)
      next_pins.wpB = sync2.wpB;
    selected   = !pins.csB;
    sckRise    = selected && pins.sck && !pinsDly.sck;
    sckFall    = selected && !pins.sck && pinsDly.sck;
    csRise     = pins.csB && !pinsDly.csB;
    lastBit    = (bitCnt == `LAST_BIT);
    inByte     = {shiftIn[`BYTE_W-2:0], pins.mosi};
    fullAddr   = {addrHi[`ADDR_TOP_W-1:0], inByte};
    hardLock   = guardLockBit && !pins.wpB;
    outPhase   = (phase == spi_eeprom_pkg::ST_RDATA) || (phase == spi_eeprom_pkg::ST_STATUS);
    decodeEvt  = sckRise && lastBit && (phase == spi_eeprom_pkg::ST_OPCODE);
    statusByte = {guardLockBit, `STATUS_PAD, guardLevelHi, guardLevelLo, armLatch, busyFlag};
    pushValid  = selected && (phase == spi_eeprom_pkg::ST_RDATA);
    commit     = busyFlag && (progCnt == `CNT_ZERO) && progArray;
    byteStore  = 1'b0;
    fifoPop    = 1'b0;
    loadByte   = `ZERO_BYTE;
    next_phase = phase;
    next_bitCnt = bitCnt;
    next_shiftIn = shiftIn;
    next_shiftOut = shiftOut;
    next_addrHi = addrHi;
    next_addrSecond = addrSecond;
    next_isWrite = isWrite;
    next_readAddr = readAddr;
    next_pageBase = pageBase;
    next_pageOffset = pageOffset;
    next_pageValid = pageValid;
    next_gotData = gotData;
    next_pendStatus = pendStatus;
    next_statusNew = statusNew;
    next_progArray = progArray;
    next_progCnt = progCnt;
    next_busy = busyFlag;
    next_arm = armLatch;
    next_lock = guardLockBit;
    next_hi = guardLevelHi;
    next_lo = guardLevelLo;
    next_miso = miso;
    next_hard = hardLock;
    next_soft = (guardLevelHi || guardLevelLo) && !hardLock;
    next_misoEnB = !(selected && outPhase);
    // self-timed cycle
    if (busyFlag)
    begin
      if (progCnt == `CNT_ZERO)
      begin
        next_busy = 1'b0;
        next_arm = 1'b0;
        if (!progArray)
        begin
          next_lock = statusNew.lock;
          next_hi = statusNew.hi;
          next_lo = statusNew.lo;
        end
      end
      else
        next_progCnt = progCnt - 1'b1;
    end
    // prefetch for sequential read
    if (pushValid && fifoReady)
      next_readAddr = readAddr + 1'b1;
    // serial input
    if (sckRise)
    begin
      next_shiftIn = inByte;
      next_bitCnt = bitCnt + 1'b1;
      if (phase == spi_eeprom_pkg::ST_IGNORE)
        next_pendStatus = 1'b0;
      if (lastBit)
      begin
        case (phase)
          spi_eeprom_pkg::ST_OPCODE:
          begin
            next_phase = spi_eeprom_pkg::ST_IGNORE;
            next_isWrite = 1'b0;
            if (inByte == `OP_READ && !busyFlag)
              next_phase = spi_eeprom_pkg::ST_ADDR;
            else if (inByte == `OP_WRITE && !busyFlag && armLatch)
            begin
              next_phase = spi_eeprom_pkg::ST_ADDR;
              next_isWrite = 1'b1;
            end
            else if (inByte == `OP_ARM)
              next_arm = 1'b1;
            else if (inByte == `OP_WRDI)
              next_arm = 1'b0;
            else if (inByte == `OP_RDSR)
              next_phase = spi_eeprom_pkg::ST_STATUS;
            else if (inByte == `OP_STATUS_SET && !busyFlag && armLatch && !hardLock)
              next_phase = spi_eeprom_pkg::ST_SDATA;
          end
          spi_eeprom_pkg::ST_ADDR:
          begin
            next_addrSecond = 1'b1;
            next_addrHi = inByte;
            if (addrSecond && !isWrite)
            begin
              next_phase = spi_eeprom_pkg::ST_RDATA;
              next_readAddr = fullAddr;
            end
            else if (addrSecond)
            begin
              next_phase = spi_eeprom_pkg::ST_WDATA;
              if (inGuard(fullAddr, guardLevelHi, guardLevelLo))
                next_phase = spi_eeprom_pkg::ST_IGNORE;
              next_pageBase = fullAddr[`ADDR_W-1:`PAGE_W];
              next_pageOffset = fullAddr[`PAGE_W-1:0];
              next_pageValid = '0;
              next_gotData = 1'b0;
            end
          end
          spi_eeprom_pkg::ST_WDATA:
          begin
            byteStore = 1'b1;
            next_gotData = 1'b1;
            next_pageValid = pageValid | (`PAGE_BYTES'(1) << pageOffset);
            next_pageOffset = pageOffset + 1'b1;
          end
          spi_eeprom_pkg::ST_SDATA:
          begin
            next_statusNew = '{lock: inByte[`LOCK_B], hi: inByte[`HI_B], lo: inByte[`LO_B]};
            next_pendStatus = 1'b1;
            next_phase = spi_eeprom_pkg::ST_IGNORE;
          end
          default:
            next_phase = phase;
        endcase
      end
    end
    // serial output on falling edge
    if (sckFall && outPhase)
    begin
      if (bitCnt == `FIRST_BIT)
      begin
        loadByte = statusByte;
        if (phase == spi_eeprom_pkg::ST_RDATA)
        begin
          loadByte = fifoValid ? fifoOut : `ZERO_BYTE;
          fifoPop = fifoValid;
        end
        next_miso = loadByte[`BYTE_W-1];
        next_shiftOut = {loadByte[`BYTE_W-2:0], 1'b0};
      end
      else
      begin
        next_miso = shiftOut[`BYTE_W-1];
        next_shiftOut = {shiftOut[`BYTE_W-2:0], 1'b0};
      end
    end
    // deselect closes the instruction
    if (csRise)
    begin
      if (phase == spi_eeprom_pkg::ST_WDATA && gotData && bitCnt == `FIRST_BIT)
      begin
        next_busy = 1'b1;
        next_progArray = 1'b1;
        next_progCnt = `CNT_W'(PROG_CYCLES - 1);
      end
      else if (pendStatus)
      begin
        next_busy = 1'b1;
        next_progArray = 1'b0;
        next_progCnt = `CNT_W'(PROG_CYCLES - 1);
      end
      next_phase = spi_eeprom_pkg::ST_OPCODE;
      next_bitCnt = `FIRST_BIT;
      next_pendStatus = 1'b0;
      next_addrSecond = 1'b0;
      next_gotData = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      sync1 <= '{sck: 1'b0, csB: 1'b1, mosi: 1'b0, wpB: 1'b1};
      sync2 <= '{sck: 1'b0, csB: 1'b1, mosi: 1'b0, wpB: 1'b1};
      sync3 <= '{sck: 1'b0, csB: 1'b1, mosi: 1'b0, wpB: 1'b1};
      pins <= '{sck: 1'b0, csB: 1'b1, mosi: 1'b0, wpB: 1'b1};
      pinsDly <= '{sck: 1'b0, csB: 1'b1, mosi: 1'b0, wpB: 1'b1};
      phase <= spi_eeprom_pkg::ST_OPCODE;
      statusNew <= '0;
      bitCnt <= `FIRST_BIT;
      shiftIn <= `ZERO_BYTE;
      shiftOut <= `ZERO_BYTE;
      addrHi <= `ZERO_BYTE;
      addrSecond <= 1'b0;
      isWrite <= 1'b0;
      readAddr <= '0;
      pageBase <= '0;
      pageOffset <= '0;
      pageValid <= '0;
      gotData <= 1'b0;
      pendStatus <= 1'b0;
      progArray <= 1'b0;
      progCnt <= `CNT_ZERO;
      miso <= 1'b0;
      misoEnB <= 1'b1;
      busyFlag <= 1'b0;
      armLatch <= 1'b0;
      guardLockBit <= 1'b0;
      guardLevelHi <= 1'b0;
      guardLevelLo <= 1'b0;
      hardLockMode <= 1'b0;
      softGuardMode <= 1'b0;
    end
    else
    begin
      sync1 <= pinIn;
      sync2 <= sync1;
      sync3 <= sync2;
      pins <= next_pins;
      pinsDly <= pins;
      phase <= next_phase;
      statusNew <= next_statusNew;
      bitCnt <= next_bitCnt;
      shiftIn <= next_shiftIn;
      shiftOut <= next_shiftOut;
      addrHi <= next_addrHi;
      addrSecond <= next_addrSecond;
      isWrite <= next_isWrite;
      readAddr <= next_readAddr;
      pageBase <= next_pageBase;
      pageOffset <= next_pageOffset;
      pageValid <= next_pageValid;
      gotData <= next_gotData;
      pendStatus <= next_pendStatus;
      progArray <= next_progArray;
      progCnt <= next_progCnt;
      miso <= next_miso;
      misoEnB <= next_misoEnB;
      busyFlag <= next_busy;
      armLatch <= next_arm;
      guardLockBit <= next_lock;
      guardLevelHi <= next_hi;
      guardLevelLo <= next_lo;
      hardLockMode <= next_hard;
      softGuardMode <= next_soft;
    end
  end

  // page buffer and array commit in one program cycle
  always_ff @(posedge clk)
  begin
    if (byteStore)
      pageBuf[pageOffset] <= inByte;
    if (commit)
      for (int i = 0; i < `PAGE_BYTES; i++)
        if (pageValid[i])
          mem[{pageBase, `PAGE_W'(i)}] <= pageBuf[i];
  end

  default clocking dc @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  busy_end_a: assert property (busyFlag && progCnt == `CNT_ZERO |=> !busyFlag && !armLatch)
    else $error("busy flag or arm latch stayed set after the cycle end");
  read_busy_a: assert property (decodeEvt && inByte == `OP_READ && busyFlag
    |=> phase == spi_eeprom_pkg::ST_IGNORE)
    else $error("read accepted during program cycle");
  write_refuse_a: assert property (decodeEvt && inByte == `OP_WRITE && (busyFlag || !armLatch)
    |=> phase == spi_eeprom_pkg::ST_IGNORE)
    else $error("array write accepted without arm or while busy");
  status_lock_a: assert property (decodeEvt && inByte == `OP_STATUS_SET && hardLock
    |=> phase == spi_eeprom_pkg::ST_IGNORE)
    else $error("status write accepted in hard lock mode");
  hard_mode_a: assert property (guardLockBit && !pins.wpB |=> hardLockMode)
    else $error("hard lock mode not entered");
  hard_exit_a: assert property (pins.wpB |=> !hardLockMode)
    else $error("hard lock mode held with protect pin high");
  guard_write_a: assert property (sckRise && lastBit && phase == spi_eeprom_pkg::ST_ADDR && isWrite
    && addrSecond && inGuard(fullAddr, guardLevelHi, guardLevelLo)
    |=> phase == spi_eeprom_pkg::ST_IGNORE)
    else $error("write into guarded region accepted");
  page_wrap_a: assert property (byteStore && pageOffset == `OFFSET_MAX |=> pageOffset == '0)
    else $error("page offset did not wrap");
  read_wrap_a: assert property (pushValid && fifoReady && readAddr == `ADDR_MAX
    |=> readAddr == '0)
    else $error("read address did not wrap to zero");
  off_boundary_a: assert property (csRise && !busyFlag && phase == spi_eeprom_pkg::ST_WDATA
    && bitCnt != `FIRST_BIT ##1 !pendStatus |-> !busyFlag)
    else $error("program cycle started off a byte boundary");

  read_two_c: cover property (fifoPop ##[1:300] fifoPop);
  page_prog_c: cover property (csRise && phase == spi_eeprom_pkg::ST_WDATA ##1 busyFlag);
  status_prog_c: cover property (csRise && pendStatus ##1 busyFlag);
  hard_enter_c: cover property ($rose(hardLockMode));
endmodule : spi_eeprom_core

// File: tb/spi_host_model.sv
// spi host model driving the eeprom pins
`timescale 1ns/100ps
module spi_host_model
(
  input  wire logic clk,
  input  wire logic miso,
  output logic      sck,
  output logic      csB,
  output logic      mosi
);
  initial
  begin
    sck = 1'b0;
    csB = 1'b1;
    mosi = 1'b0;
  end
  task automatic sel();
    repeat (4) @(posedge clk);
    csB <= 1'b0;
  endtask : sel
  // released data line toggles so stale bits never look valid
  task automatic desel();
    csB <= 1'b1;
    mosi <= ~mosi;
  endtask : desel
  // one bit per 8 clk, msb first, data out taken halfway through the high phase
  task automatic xfer(input logic [7:0] tx, input int nBits, output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 7; i > 7 - nBits; i--)
    begin
      @(posedge clk);
      sck <= 1'b0;
      mosi <= tx[i];
      repeat (4) @(posedge clk);
      sck <= 1'b1;
      repeat (2) @(posedge clk);
      rx[i] = miso;
      @(posedge clk);
    end
    @(posedge clk);
    sck <= 1'b0;
  endtask : xfer
endmodule : spi_host_model

// File: tb/spi_eeprom_core_tb_top.sv
// self-checking bench for the spi eeprom core
`timescale 1ns/100ps
`include "spi_eeprom_consts.svh"
module spi_eeprom_core_tb_top;
  localparam int PROG = 200;
  typedef struct packed {logic [7:0] guard; logic [10:0] addr; logic ok;} row_type;
  logic       clk, rst_b, writeProtectB, sck, csB, mosi, miso, misoEnB;
  logic       busyFlag, armLatch, guardLockBit, guardLevelHi, guardLevelLo;
  logic       hardLockMode, softGuardMode;
  logic       misoLine;
  // undriven data line reads as the inverse
  assign misoLine = misoEnB ? ~miso : miso;
  logic [7:0] rb;
  logic [7:0] shadow [2048];
  int         fails = 0;
  int         totalChecks = 0;
  row_type    rows [6] = '{'{8'h04, 11'h5ff, 1'b1}, '{8'h04, 11'h600, 1'b0},
    '{8'h08, 11'h3ff, 1'b1}, '{8'h08, 11'h400, 1'b0}, '{8'h0c, 11'h000, 1'b0},
    '{8'h00, 11'h7ff, 1'b1}};
  spi_eeprom_core #(.PROG_CYCLES(PROG)) i_spi_eeprom_core
  (
    .clk, .rst_b, .sck, .csB, .mosi, .writeProtectB, .miso, .misoEnB, .busyFlag,
    .armLatch, .guardLockBit, .guardLevelHi, .guardLevelLo, .hardLockMode, .softGuardMode
  );
  spi_host_model i_spi_host_model
  (
    .clk, .miso (misoLine), .sck, .csB, .mosi
  );
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic checkWord(input logic [15:0] got, input logic [15:0] exp);
    totalChecks++;
    if (got !== exp)
    begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : checkWord
  task automatic checkBit(input logic got, input logic exp);
    checkWord({15'h0000, got}, {15'h0000, exp});
  endtask : checkBit
  task automatic checkByte(input logic [7:0] got, input logic [7:0] exp);
    checkWord({8'h00, got}, {8'h00, exp});
  endtask : checkByte
  task automatic test_done();
    $display("checks %0d mismatches %0d", totalChecks, fails);
    if (fails == 0 && totalChecks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : test_done
  task automatic shift8(input logic [7:0] b);
    i_spi_host_model.xfer(b, 8, rb);
  endtask : shift8
  task automatic cmd(input logic [7:0] op);
    i_spi_host_model.sel();
    shift8(op);
    i_spi_host_model.desel();
  endtask : cmd
  // waits for the program cycle and measures it
  task automatic cycleEnd(input logic expBusy);
    int n;
    n = 0;
    while (busyFlag !== 1'b1 && n < 12)
    begin
      @(posedge clk);
      n++;
    end
    checkBit(busyFlag, expBusy);
    n = 0;
    while (busyFlag === 1'b1 && n < 1000)
    begin
      @(posedge clk);
      n++;
    end
    if (expBusy)
    begin
      checkWord(16'(n), 16'(PROG));
      checkBit(armLatch, 1'b0);
    end
  endtask : cycleEnd
  task automatic writeMem(input logic [10:0] a, input logic [7:0] d, input int n,
                          input logic arm, input logic ok, input logic hold);
    if (arm)
      cmd(`OP_ARM);
    i_spi_host_model.sel();
    shift8(`OP_WRITE);
    shift8({5'h1f, a[10:8]});
    shift8(a[7:0]);
    for (int i = 0; i < n; i++)
    begin
      shift8(d + 8'(i));
      if (ok)
        shadow[{a[10:5], a[4:0] + 5'(i)}] = d + 8'(i);
    end
    i_spi_host_model.desel();
    if (!hold)
      cycleEnd(ok);
  endtask : writeMem
  task automatic readMem(input logic [10:0] a, input int n);
    i_spi_host_model.sel();
    shift8(`OP_READ);
    shift8({5'h00, a[10:8]});
    shift8(a[7:0]);
    for (int i = 0; i < n; i++)
    begin
      shift8(8'h00);
      checkByte(rb, shadow[a + 11'(i)]);
    end
    checkBit(misoEnB, 1'b0);
    i_spi_host_model.desel();
  endtask : readMem
  task automatic setGuard(input logic [7:0] g, input logic ok);
    cmd(`OP_ARM);
    i_spi_host_model.sel();
    shift8(`OP_STATUS_SET);
    shift8(g);
    i_spi_host_model.desel();
    cycleEnd(ok);
    if (ok)
      checkByte({guardLockBit, 3'h0, guardLevelHi, guardLevelLo, 2'h0}, g);
  endtask : setGuard
  task automatic pinSet(input logic v);
    @(posedge clk);
    writeProtectB <= v;
    repeat (8) @(posedge clk);
  endtask : pinSet
  initial
  begin
    #4000000;
    fails++;
    test_done();
  end
  initial
  begin
    rst_b = 1'b0;
    writeProtectB = 1'b1;
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    repeat (8) @(posedge clk);
    checkByte({busyFlag, armLatch, guardLockBit, guardLevelHi, guardLevelLo,
               hardLockMode, softGuardMode, misoEnB}, 8'h01);
    cmd(`OP_ARM);
    repeat (8) @(posedge clk);
    checkBit(armLatch, 1'b1);
    cmd(`OP_WRDI);
    repeat (8) @(posedge clk);
    checkBit(armLatch, 1'b0);
    $display("test reset and arm done");
    foreach (rows[r])
    begin
      setGuard(8'h00, 1'b1);
      writeMem(rows[r].addr, 8'h5a, 1, 1'b1, 1'b1, 1'b0);
      setGuard(rows[r].guard, 1'b1);
      writeMem(rows[r].addr, 8'ha0 + 8'(r), 1, 1'b1, rows[r].ok, 1'b0);
      readMem(rows[r].addr, 1);
    end
    $display("test guard table done");
    writeMem(11'h01e, 8'h10, 34, 1'b1, 1'b1, 1'b0);
    readMem(11'h000, 32);
    readMem(11'h7ff, 2);
    $display("test page and wrap done");
    writeMem(11'h000, 8'h55, 1, 1'b0, 1'b0, 1'b0);
    cmd(`OP_ARM);
    i_spi_host_model.sel();
    shift8(`OP_WRITE);
    shift8(8'h00);
    shift8(8'h00);
    shift8(8'h77);
    i_spi_host_model.xfer(8'h99, 4, rb);
    i_spi_host_model.desel();
    cycleEnd(1'b0);
    i_spi_host_model.sel();
    for (int i = 0; i < 4; i++)
      shift8(8'h07);
    checkBit(misoEnB, 1'b1);
    i_spi_host_model.desel();
    readMem(11'h000, 1);
    $display("test refusals done");
    writeMem(11'h140, 8'h3c, 1, 1'b1, 1'b1, 1'b1);
    i_spi_host_model.sel();
    shift8(`OP_READ);
    shift8(8'h01);
    shift8(8'h40);
    shift8(8'h00);
    checkBit(misoEnB, 1'b1);
    i_spi_host_model.desel();
    cycleEnd(1'b0);
    writeMem(11'h141, 8'h3d, 1, 1'b1, 1'b1, 1'b1);
    writeMem(11'h000, 8'h66, 1, 1'b1, 1'b0, 1'b0);
    readMem(11'h140, 2);
    readMem(11'h000, 1);
    $display("test busy done");
    pinSet(1'b0);
    setGuard(8'h84, 1'b1);
    i_spi_host_model.sel();
    shift8(`OP_RDSR);
    shift8(8'h00);
    checkByte(rb, 8'h84);
    i_spi_host_model.desel();
    checkBit(hardLockMode, 1'b1);
    setGuard(8'h00, 1'b0);
    checkBit(guardLevelLo, 1'b1);
    writeMem(11'h5f0, 8'h21, 1, 1'b1, 1'b1, 1'b0);
    writeMem(11'h600, 8'h22, 1, 1'b1, 1'b0, 1'b0);
    pinSet(1'b1);
    checkBit(hardLockMode, 1'b0);
    checkBit(softGuardMode, 1'b1);
    setGuard(8'h80, 1'b1);
    pinSet(1'b0);
    checkBit(hardLockMode, 1'b1);
    pinSet(1'b1);
    setGuard(8'h00, 1'b1);
    $display("test hard lock done");
    test_done();
  end
endmodule : spi_eeprom_core_tb_top
